// >>> inc/dom_pkg.sv
// constants and types for the digital output source multiplexer
// assumes a single 100 MHz clock and a plain register port
// What this block does
// R01 - eight outputs, each with its own selector
// R02 - sources: direct, PWM, waveform, SENT, sensor
// R03 - selected source alone times the low switch
// R04 - switch closed gives low, open gives high
// R05 - cutoff closed while generating, open disconnects
// R06 - per-output mode: open collector or pull-up
// R07 - PWM frequency 0 to 100 kHz, duty 0..1; periods below PWM_MIN_PER are accepted, so faster PWM is possible
// R08 - SENT source only on four channels
// R09 - direct level is software written, unmodulated
// R10 - unused selection keeps low switch open
package dom_pkg;
   localparam int unsigned NUM_OUT     = 8;     // output channels
   localparam int unsigned NUM_SENT    = 4;     // channels with a SENT source
   localparam int unsigned ADDR_W      = 8;     // register address width
   localparam int unsigned DATA_W      = 32;    // register data width
   localparam int unsigned SEL_W       = 3;     // source select field width
   localparam int unsigned CLK_HZ      = 100000000;
   localparam int unsigned PWM_MAX_HZ  = 100000;
   // shortest legal pwm period in clocks
   localparam int unsigned PWM_MIN_PER = CLK_HZ / PWM_MAX_HZ;
   localparam int unsigned PER_W       = 24;    // pwm period counter width
   // register offsets
   localparam logic [ADDR_W-1:0] REG_SEL    = 8'h00; // 8 x 3-bit source select
   localparam logic [ADDR_W-1:0] REG_MODE   = 8'h04; // output mode bits
   localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h08; // cutoff close bits
   localparam logic [ADDR_W-1:0] REG_LEVEL  = 8'h0c; // direct level bits
   localparam logic [ADDR_W-1:0] REG_STAT   = 8'h10; // live switch state
   localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h20; // base of 8 pwm periods
   localparam logic [ADDR_W-1:0] REG_HIGH   = 8'h40; // base of 8 pwm high times
   localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04; // word stride
   localparam logic [ADDR_W-1:0] IDX_MASK   = 8'h1c; // index field inside a bank
   localparam int unsigned       IDX_LSB    = 2;
   localparam logic [DATA_W-1:0] RD_ZERO    = 32'h0000_0000;
   // source encodings
   typedef enum logic [SEL_W-1:0] {
      DOM_SRC_UNUSED = 3'h0,
      DOM_SRC_DIRECT = 3'h1,
      DOM_SRC_PWM    = 3'h2,
      DOM_SRC_WAVE   = 3'h3,
      DOM_SRC_SENT   = 3'h4,
      DOM_SRC_SENSOR = 3'h5
   } dom_src_t;
endpackage

// >>> inc/dom_pwm_if.sv
// pwm settings and outputs passed between top and pwm bank
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface dom_pwm_if;
   import dom_pkg::*;
   logic [PER_W-1:0] period [NUM_OUT]; // clocks per cycle, 0 stops
   logic [PER_W-1:0] high_t [NUM_OUT]; // clocks high per cycle
   logic [NUM_OUT-1:0] level;          // generated levels
   modport ctrl (output period, output high_t, input level);
   modport gen  (input period, input high_t, output level);
endinterface
`default_nettype wire

// >>> hdl/dom_pwm_bank.sv
// eight pwm generators, one per output
// assumes settings come from same-clock registers
`timescale 1ns/1ps
`default_nettype none
module dom_pwm_bank
   import dom_pkg::*;
(
   input  wire logic REF_CLK,
   input  wire logic NRST,
   input  wire logic CLK_EN,
   dom_pwm_if.gen    pwm
);
   logic [PER_W-1:0]   cnt_q [NUM_OUT]; // phase counters
   logic [PER_W-1:0]   cnt_d [NUM_OUT];
   logic [NUM_OUT-1:0] lvl_q;           // registered levels
   logic [NUM_OUT-1:0] lvl_d;

   // next phase and level for each channel
   always_comb
   begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
         // R07 frequency and duty
         if (pwm.period[i] == '0)
         begin
            // zero frequency: hold level by duty (0 -> low, else high)
            cnt_d[i] = '0;
            lvl_d[i] = (pwm.high_t[i] != '0);
         end
         else
         begin
            cnt_d[i] = (cnt_q[i] + PER_W'(1) >= pwm.period[i]) ? '0 : cnt_q[i] + PER_W'(1);
            // duty of 1.0 when high time reaches the period
            lvl_d[i] = (cnt_d[i] < pwm.high_t[i]);
         end
      end
   end

   // register phase state
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         for (int i = 0; i < NUM_OUT; i++)
         begin
            cnt_q[i] <= '0;
         end
         lvl_q <= '0;
      end
      else if (CLK_EN)
      begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
      end
   end

   assign pwm.level = lvl_q;
endmodule
`default_nettype wire

// >>> hdl/dom_top.sv
// digital output source multiplexer with register port
// assumes external sources are asynchronous and get synchronised here
`timescale 1ns/1ps
`default_nettype none
module dom_top
   import dom_pkg::*;
(
   input  wire logic                REF_CLK,
   input  wire logic                NRST,
   input  wire logic                CLK_EN,
   input  wire logic [ADDR_W-1:0]   ADDR,
   input  wire logic [DATA_W-1:0]   WDATA,
   input  wire logic                WR,
   input  wire logic                RD,
   output logic      [DATA_W-1:0]   RDATA,
   input  wire logic [NUM_OUT-1:0]  WAVE_IN,
   input  wire logic [NUM_SENT-1:0] SENT_IN,
   input  wire logic                SENSOR_IN,
   output logic      [NUM_OUT-1:0]  FAST_LOW_SIDE_SWITCH,
   output logic      [NUM_OUT-1:0]  OUTPUT_CUTOFF_SWITCH,
   output logic      [NUM_OUT-1:0]  OUTPUT_MODE_SWITCH
);
   localparam int unsigned EXT_W = NUM_OUT + NUM_SENT + 1; // async inputs

   // software registers
   logic [SEL_W*NUM_OUT-1:0] sel_q, sel_d;     // packed source selects
   logic [NUM_OUT-1:0]       mode_q, mode_d;   // 1 = internal pull-up
   logic [NUM_OUT-1:0]       en_q, en_d;       // 1 = cutoff closed
   logic [NUM_OUT-1:0]       lvl_q, lvl_d;     // direct levels
   logic [PER_W-1:0]         per_q [NUM_OUT];  // pwm periods
   logic [PER_W-1:0]         per_d [NUM_OUT];
   logic [PER_W-1:0]         hi_q  [NUM_OUT];  // pwm high times
   logic [PER_W-1:0]         hi_d  [NUM_OUT];
   logic [DATA_W-1:0]        rdata_q, rdata_d; // read data
   // outputs
   logic [NUM_OUT-1:0]       fls_q, fls_d;     // low switch closed
   logic [NUM_OUT-1:0]       cut_q, cut_d;     // cutoff closed
   // synchronisers
   logic [EXT_W-1:0]         ext_s1_q;         // first stage only
   logic [EXT_W-1:0]         ext_s2_q;         // usable samples
   logic [NUM_OUT-1:0]       wave_s;
   logic [NUM_SENT-1:0]      sent_s;
   logic                     sensor_s;

   dom_pwm_if pwm_c ();

   // pwm bank instance
   dom_pwm_bank u_pwm
   (
      .REF_CLK (REF_CLK),
      .NRST    (NRST),
      .CLK_EN  (CLK_EN),
      .pwm     (pwm_c.gen)
   );

   assign pwm_c.period = per_q;
   assign pwm_c.high_t = hi_q;

   // word index inside a register bank
   function automatic int unsigned bank_idx(input logic [ADDR_W-1:0] a,
                                            input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] off;
      off = a - base;
      return int'(off[IDX_LSB +: SEL_W]);
   endfunction

   // true when address falls in a bank of NUM_OUT words
   function automatic logic in_bank(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] off;
      off = a - base;
      return (a >= base) && ((off & ~IDX_MASK) == '0);
   endfunction

   // two-stage sync of all external sources
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
      end
      else if (CLK_EN)
      begin
         ext_s1_q <= {SENSOR_IN, SENT_IN, WAVE_IN};
         ext_s2_q <= ext_s1_q;
      end
   end

   assign wave_s   = ext_s2_q[NUM_OUT-1:0];
   assign sent_s   = ext_s2_q[NUM_OUT +: NUM_SENT];
   assign sensor_s = ext_s2_q[EXT_W-1];

   // register writes and read decode
   always_comb
   begin
      sel_d   = sel_q;
      mode_d  = mode_q;
      en_d    = en_q;
      lvl_d   = lvl_q;
      per_d   = per_q;
      hi_d    = hi_q;
      rdata_d = RD_ZERO;
      if (WR)
      begin
         // R01 independent selects
         if (ADDR == REG_SEL)
         begin
            sel_d = WDATA[SEL_W*NUM_OUT-1:0];
         end
         // R06 mode per output
         else if (ADDR == REG_MODE)
         begin
            mode_d = WDATA[NUM_OUT-1:0];
         end
         else if (ADDR == REG_ENABLE)
         begin
            en_d = WDATA[NUM_OUT-1:0];
         end
         // R09 software level
         else if (ADDR == REG_LEVEL)
         begin
            lvl_d = WDATA[NUM_OUT-1:0];
         end
         // R07 pwm period set
         else if (in_bank(ADDR, REG_PERIOD))
         begin
            per_d[bank_idx(ADDR, REG_PERIOD)] = WDATA[PER_W-1:0];
         end
         else if (in_bank(ADDR, REG_HIGH))
         begin
            hi_d[bank_idx(ADDR, REG_HIGH)] = WDATA[PER_W-1:0];
         end
      end
      if (RD)
      begin
         if (ADDR == REG_SEL)
         begin
            rdata_d[SEL_W*NUM_OUT-1:0] = sel_q;
         end
         else if (ADDR == REG_MODE)
         begin
            rdata_d[NUM_OUT-1:0] = mode_q;
         end
         else if (ADDR == REG_ENABLE)
         begin
            rdata_d[NUM_OUT-1:0] = en_q;
         end
         else if (ADDR == REG_LEVEL)
         begin
            rdata_d[NUM_OUT-1:0] = lvl_q;
         end
         // live switch state
         else if (ADDR == REG_STAT)
         begin
            rdata_d[NUM_OUT-1:0]         = fls_q;
            rdata_d[NUM_OUT +: NUM_OUT]  = cut_q;
         end
         else if (in_bank(ADDR, REG_PERIOD))
         begin
            rdata_d[PER_W-1:0] = per_q[bank_idx(ADDR, REG_PERIOD)];
         end
         else if (in_bank(ADDR, REG_HIGH))
         begin
            rdata_d[PER_W-1:0] = hi_q[bank_idx(ADDR, REG_HIGH)];
         end
         // unmapped reads return zero
      end
   end

   // per-output source multiplexer
   always_comb
   begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
         logic src_lvl;
         src_lvl = 1'b1;
         // R02 source choice
         case (dom_src_t'(sel_q[i*SEL_W +: SEL_W]))
            DOM_SRC_DIRECT: src_lvl = lvl_q[i];
            DOM_SRC_PWM:    src_lvl = pwm_c.level[i];
            DOM_SRC_WAVE:   src_lvl = wave_s[i];
            // R08 sent only on low four
            DOM_SRC_SENT:   src_lvl = (i < NUM_SENT) ? sent_s[i % NUM_SENT] : 1'b1;
            DOM_SRC_SENSOR: src_lvl = sensor_s;
            // R10 unused keeps switch open
            default:        src_lvl = 1'b1;
         endcase
         // R03 selected source times switch
         // R04 closed for low phase
         fls_d[i] = en_q[i] & ~src_lvl;
         // R05 cutoff closed while active
         cut_d[i] = en_q[i];
      end
   end

   // register state and outputs
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         sel_q   <= '0;
         mode_q  <= '0;
         en_q    <= '0;
         lvl_q   <= '0;
         for (int i = 0; i < NUM_OUT; i++)
         begin
            per_q[i] <= '0;
            hi_q[i]  <= '0;
         end
         rdata_q <= RD_ZERO;
         fls_q   <= '0;
         cut_q   <= '0;
      end
      else if (CLK_EN)
      begin
         sel_q   <= sel_d;
         mode_q  <= mode_d;
         en_q    <= en_d;
         lvl_q   <= lvl_d;
         per_q   <= per_d;
         hi_q    <= hi_d;
         rdata_q <= rdata_d;
         fls_q   <= fls_d;
         cut_q   <= cut_d;
      end
   end

   assign RDATA                = rdata_q;
   assign FAST_LOW_SIDE_SWITCH = fls_q;
   assign OUTPUT_CUTOFF_SWITCH = cut_q;
   assign OUTPUT_MODE_SWITCH   = mode_q;
endmodule
`default_nettype wire

// >>> bench/dom_monitor.sv
// port checker for the output multiplexer
// assumes bind onto dom_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dom_monitor
   import dom_pkg::*;
(
   input wire logic                REF_CLK,
   input wire logic                NRST,
   input wire logic                CLK_EN,
   input wire logic [ADDR_W-1:0]   ADDR,
   input wire logic [DATA_W-1:0]   WDATA,
   input wire logic                WR,
   input wire logic                RD,
   input wire logic [DATA_W-1:0]   RDATA,
   input wire logic [NUM_OUT-1:0]  WAVE_IN,
   input wire logic [NUM_SENT-1:0] SENT_IN,
   input wire logic                SENSOR_IN,
   input wire logic [NUM_OUT-1:0]  FAST_LOW_SIDE_SWITCH,
   input wire logic [NUM_OUT-1:0]  OUTPUT_CUTOFF_SWITCH,
   input wire logic [NUM_OUT-1:0]  OUTPUT_MODE_SWITCH
);
   logic [23:0] sel_s;           // shadow of selections
   logic [7:0]  en_s;            // shadow of enables
   logic [7:0]  lv_s;            // shadow of direct levels
   logic [7:0]  chk;             // channels with fixed answer
   logic [7:0]  exp_f;           // expected switch there
   logic [7:0]  sen_m;           // channels on sensor
   wire  [7:0]  wd8 = WDATA[7:0];
   wire         wr_ok = WR && CLK_EN;
   wire         mode_wr = wr_ok && ADDR == REG_MODE;
   // shadow registers follow taken writes
   always_ff @(posedge REF_CLK or negedge NRST)
      if (!NRST)
         {sel_s, en_s, lv_s} <= '0;
      else if (wr_ok && ADDR == REG_SEL)
         sel_s <= WDATA[23:0];
      else if (wr_ok && ADDR == REG_ENABLE)
         en_s <= wd8;
      else if (wr_ok && ADDR == REG_LEVEL)
         lv_s <= wd8;
   // per channel expectation from shadows
   always_comb
      for (int i = 0; i < 8; i++)
      begin
         chk[i] = sel_s[3*i+:3] inside {3'h0, 3'h1, 3'h6, 3'h7}
                  || (sel_s[3*i+:3] == DOM_SRC_SENT && i > 3);
         exp_f[i] = en_s[i] && sel_s[3*i+:3] == DOM_SRC_DIRECT && !lv_s[i];
         sen_m[i] = sel_s[3*i+:3] == DOM_SRC_SENSOR;
      end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   a_rdata_idle: assert property (
      $past(CLK_EN) && !$past(RD) |-> RDATA == RD_ZERO) else $error("read data not idle");
   a_mode_write: assert property (
      mode_wr |=> OUTPUT_MODE_SWITCH == $past(wd8)) else $error("mode not written");
   a_mode_hold: assert property (
      $changed(OUTPUT_MODE_SWITCH) |-> $past(mode_wr)) else $error("mode changed alone");
   a_cutoff_write: assert property (
      wr_ok && ADDR == REG_ENABLE ##1 CLK_EN |=> OUTPUT_CUTOFF_SWITCH == $past(wd8, 2))
      else $error("cutoff not following enable");
   a_cut_gates: assert property (
      (FAST_LOW_SIDE_SWITCH & ~OUTPUT_CUTOFF_SWITCH) == 8'h00) else $error("switch on while cut");
   a_direct_path: assert property (
      $past(CLK_EN) |-> ((FAST_LOW_SIDE_SWITCH ^ $past(exp_f)) & $past(chk)) == 8'h00)
      else $error("direct or unused switch wrong");
   a_sensor_path: assert property (
      $past(CLK_EN) && $past(CLK_EN, 2) && $past(CLK_EN, 3) &&
      sel_s == $past(sel_s, 3) && en_s == $past(en_s, 3) |->
      ((FAST_LOW_SIDE_SWITCH ^ (en_s & ~{8{$past(SENSOR_IN, 3)}})) & sen_m) == 8'h00)
      else $error("sensor switch wrong");
   a_freeze_all: assert property (
      !CLK_EN |=> $stable({FAST_LOW_SIDE_SWITCH, OUTPUT_CUTOFF_SWITCH, RDATA}))
      else $error("outputs moved while frozen");
endmodule
bind dom_top dom_monitor dom_monitor_inst (.REF_CLK(REF_CLK), .NRST(NRST), .CLK_EN(CLK_EN),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WAVE_IN(WAVE_IN),
   .SENT_IN(SENT_IN), .SENSOR_IN(SENSOR_IN), .FAST_LOW_SIDE_SWITCH(FAST_LOW_SIDE_SWITCH),
   .OUTPUT_CUTOFF_SWITCH(OUTPUT_CUTOFF_SWITCH), .OUTPUT_MODE_SWITCH(OUTPUT_MODE_SWITCH));
`default_nettype wire

// >>> bench/dom_ecu_model.sv
// control unit digital inputs seen through the switches
// assumes switch outputs of dom_top; input pulls low when cut off
`timescale 1ns/1ps
`default_nettype none
module dom_ecu_model
   import dom_pkg::*;
#(
   parameter logic EXT_PULL = 1'b1    // external pull-up fitted
)
(
   input  wire logic [NUM_OUT-1:0] fast_sw,
   input  wire logic [NUM_OUT-1:0] cut_sw,
   input  wire logic [NUM_OUT-1:0] mode_sw,
   output logic      [NUM_OUT-1:0] pin_lvl   // level at the unit
);
   always_comb
      for (int i = 0; i < NUM_OUT; i++)
         pin_lvl[i] = cut_sw[i] && !fast_sw[i] && (mode_sw[i] || EXT_PULL);
endmodule
`default_nettype wire

// >>> bench/dom_top_tb.sv
// self-checking bench for the output multiplexer
// assumes dom_top with checker bound and the control unit model
`timescale 1ns/1ps
`default_nettype none
module dom_top_tb;
   import dom_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0, sens = 1'b0;
   logic [7:0]  addr = 8'h00, wave = 8'h00, fast, cut, mode, pin;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  sent = 4'h0;
   int          error_cnt = 0, check_count = 0, cyc = 0;
   logic [7:0]  ra [6] = '{REG_SEL, REG_MODE, REG_ENABLE, REG_LEVEL, REG_STAT, 8'h7c};
   logic [7:0]  exp_src [8] = '{8'h00, 8'ha5, 8'hff, 8'hc3, 8'h09, 8'hff, 8'h00, 8'h00};
   dom_top dom_top_inst (.REF_CLK(clk), .NRST(nrst), .CLK_EN(clk_en), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .WAVE_IN(wave), .SENT_IN(sent),
      .SENSOR_IN(sens), .FAST_LOW_SIDE_SWITCH(fast), .OUTPUT_CUTOFF_SWITCH(cut),
      .OUTPUT_MODE_SWITCH(mode));
   dom_ecu_model dom_ecu_model_inst (.fast_sw(fast), .cut_sw(cut), .mode_sw(mode),
      .pin_lvl(pin));
   always #5 clk = ~clk;
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
         error_cnt++;
      if (got !== exp)
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // closed-cycle count of channel 0 over 100 clocks
   task automatic pwm_run(input logic [31:0] p, input logic [31:0] h, input int exp_n);
      int n;
      n = 0;
      wr_reg(REG_PERIOD, p);
      wr_reg(REG_HIGH, h);
      wait_n(10);
      repeat (100)
      begin
         @(posedge clk);
         #1;
         // an unknown switch level spoils the count on purpose
         n += (fast[0] === 1'b0) ? 0 : ((fast[0] === 1'b1) ? 1 : 1000);
      end
      chk(n, exp_n);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      foreach (ra[k]) rd_chk(ra[k], 32'h0);
      $display("reset values done");
      wr_reg(REG_ENABLE, 32'hff);
      wr_reg(REG_MODE, 32'h0f);
      wr_reg(REG_LEVEL, 32'h5a);
      wave <= 8'h3c;
      sent <= 4'h6;
      for (int s = 0; s < 8; s++)
      begin
         wr_reg(REG_SEL, {8'h0, {8{s[2:0]}}});
         wait_n(6);
         chk(fast, exp_src[s]);
      end
      rd_chk(REG_SEL, 32'h00ffffff);
      wr_reg(REG_SEL, 32'h249249);
      wait_n(3);
      chk({mode, fast, pin}, 24'h0fa55a);
      rd_chk(REG_STAT, 32'hffa5);
      wr_reg(REG_STAT, 32'h0);
      rd_chk(REG_MODE, 32'h0f);
      wr_reg(REG_ENABLE, 32'h0f);
      wait_n(3);
      chk({cut, fast, pin}, 24'h0f050a);
      $display("direct and cutoff done");
      wr_reg(REG_SEL, 32'hb6db6d);
      sens <= 1'b1;
      wait_n(5);
      chk(fast, 8'h00);
      @(posedge clk);
      sens <= 1'b0;
      wait_n(5);
      chk(fast, 8'h0f);
      @(posedge clk);
      clk_en <= 1'b0;
      wr_reg(REG_ENABLE, 32'h0);
      clk_en <= 1'b1;
      rd_chk(REG_ENABLE, 32'h0f);
      $display("sensor and freeze done");
      wr_reg(REG_SEL, 32'h2);
      pwm_run(32'd10, 32'd3, 70);
      pwm_run(32'd10, 32'd0, 100);
      pwm_run(32'd10, 32'd10, 0);
      pwm_run(32'd0, 32'd1, 0);
      // last bank word, upper bits dropped, channel 0 untouched
      wr_reg(REG_HIGH + 8'h1c, 32'hffab_cdef);
      rd_chk(REG_HIGH + 8'h1c, 32'h00ab_cdef);
      rd_chk(REG_PERIOD + 8'h1c, 32'h0);
      rd_chk(REG_HIGH, 32'h1);
      $display("pwm done");
      @(posedge clk);
      nrst <= 1'b0;
      wait_n(2);
      chk(cut, 8'h00);
      @(posedge clk);
      nrst <= 1'b1;
      rd_chk(REG_ENABLE, 32'h0);
      $display("second reset done");
      close_out();
   end
endmodule
`default_nettype wire
